// File: src/cmcs_pkg.sv
// Constants and types of the codec mute and clock supervisor.
// Assumes a 125 MHz ref_clk and a free master clock on a second domain.

package cmcs_pkg;

    localparam int CLK_PERIOD_NS = 8;
    localparam int INIT_TIME_NS = 10000;
    localparam int INIT_CYCLES = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MCLK_LOSS_NS = 1000;
    localparam int MCLK_LOSS_CYCLES = (MCLK_LOSS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int NUM_CH = 6;
    localparam int SAMPLE_W = 24;
    localparam int VOL_W = 8;
    localparam int RATIO_W = 10;
    localparam int ZRUN_W = 10;
    localparam int INIT_W = 11;
    localparam int LOSS_W = 8;

    typedef logic signed [SAMPLE_W-1:0] cmcs_sample_t;
    typedef logic [VOL_W-1:0] cmcs_vol_t;
    typedef logic [RATIO_W-1:0] cmcs_ratio_t;

    localparam logic [7:0] MUTE2_ADDR = 8'h05;
    localparam logic [7:0] MUTE2_RESET = 8'h00;
    localparam int MUTE2_SW_MUTE_BIT = 7;
    localparam int MUTE2_ZERO_EN_BIT = 6;

    localparam logic [7:0] VOL_FIRST_ADDR = 8'h07;
    localparam cmcs_vol_t VOL_RESET = 8'h00;
    localparam cmcs_vol_t VOL_MAX = 8'hB5;
    localparam cmcs_vol_t STEPS_PER_HALVING = 8'h0C;

    localparam logic [1:0] ROLE_SLAVE = 2'h0;
    localparam logic [1:0] ROLE_MASTER = 2'h3;

    localparam logic [ZRUN_W-1:0] ZERO_RUN_LEN = 10'h200;
    localparam logic STRAP_TWO_WIRE_LEVEL = 1'b0;

    localparam logic [INIT_W-1:0] INIT_COUNT = INIT_W'(INIT_CYCLES);
    localparam logic [LOSS_W-1:0] LOSS_COUNT = LOSS_W'(MCLK_LOSS_CYCLES);

    localparam cmcs_ratio_t BASE_RATIO [4] = '{10'h080, 10'h100, 10'h180, 10'h200};
    localparam cmcs_ratio_t HIGH_RATIO [4] = '{10'h040, 10'h080, 10'h0C0, 10'h100};

    localparam logic [15:0] GAIN_FRAC [12] = '{
        16'h4000, 16'h3C6B, 16'h390B, 16'h35DA, 16'h32D6, 16'h2FFE,
        16'h2D4F, 16'h2AC6, 16'h2862, 16'h2620, 16'h23FE, 16'h21FB
    };
    localparam int GAIN_FRAC_BITS = 14;

endpackage

// File: src/cmcs_link_if.sv
// Signals between the supervisor core and its master-clock side.
// Core side runs on ref_clk, link side on the master clock.
`timescale 1ns/100ps
`default_nettype none

interface cmcs_link_if;
    logic [1:0] ratio_sel;
    logic high_rate;
    logic [1:0] role;
    logic ratio_ok;
    logic heartbeat;

    modport core (
        output ratio_sel,
        output high_rate,
        output role,
        input ratio_ok,
        input heartbeat
    );

    modport link (
        input ratio_sel,
        input high_rate,
        input role,
        output ratio_ok,
        output heartbeat
    );
endinterface

`default_nettype wire

// File: src/cmcs_link.sv
// Master-clock side: word select generation and frame ratio check.
// Assumes configuration levels from ref_clk that change rarely.
`timescale 1ns/100ps
`default_nettype none

module cmcs_link
    import cmcs_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    cmcs_link_if.link lnk,
    input wire logic word_select_clock_in,
    output logic word_select_clock_out,
    output logic word_select_clock_oe,
    output logic channel_is_left,
    output logic adc_pair_start
);

    logic [1:0] rst_sync_reg;
    logic link_rst;
    logic [1:0] sel_meta_reg, sel_sync_reg;
    logic hr_meta_reg, hr_sync_reg;
    logic [1:0] role_meta_reg, role_sync_reg;
    logic ws_meta_reg, ws_sync_reg;
    logic ws_prev_reg;
    logic ws_out_reg;
    cmcs_ratio_t cnt_reg;
    cmcs_ratio_t ratio;
    logic ratio_ok_reg;
    logic [2:0] hb_reg;
    logic master, slave, ws_level, left_start;

    ////////////////////////////////////////////////////////////////
    // Reset and crossings into this domain.

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rst_sync_reg <= 2'h3;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b0};
        end
    end
    assign link_rst = rst_sync_reg[1];

    always_ff @(posedge mclk) begin
        sel_meta_reg <= lnk.ratio_sel;
        sel_sync_reg <= sel_meta_reg;
        hr_meta_reg <= lnk.high_rate;
        hr_sync_reg <= hr_meta_reg;
        role_meta_reg <= lnk.role;
        role_sync_reg <= role_meta_reg;
        ws_meta_reg <= word_select_clock_in;
        ws_sync_reg <= ws_meta_reg;
    end

    ////////////////////////////////////////////////////////////////
    // Frame timing.

    assign ratio = hr_sync_reg ? HIGH_RATIO[sel_sync_reg] : BASE_RATIO[sel_sync_reg];
    assign master = (role_sync_reg == ROLE_MASTER);
    assign slave = (role_sync_reg == ROLE_SLAVE);
    assign ws_level = master ? ws_out_reg : ws_sync_reg;
    assign left_start = ws_prev_reg & ~ws_level;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cnt_reg <= '0;
        end else if (link_rst) begin
            cnt_reg <= '0;
        end else if (master) begin
            cnt_reg <= (cnt_reg == ratio - 10'h001) ? '0 : cnt_reg + 10'h001;
        end else if (left_start) begin
            cnt_reg <= '0;
        end else if (cnt_reg != 10'h3FF) begin
            cnt_reg <= cnt_reg + 10'h001;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ws_out_reg <= 1'b0;
            ws_prev_reg <= 1'b0;
            channel_is_left <= 1'b1;
            adc_pair_start <= 1'b0;
        end else begin
            ws_out_reg <= master & (cnt_reg >= {1'b0, ratio[RATIO_W-1:1]});
            ws_prev_reg <= ws_level;
            channel_is_left <= ~ws_level;
            adc_pair_start <= left_start & ~link_rst;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ratio_ok_reg <= 1'b0;
        end else if (link_rst || !(master || slave)) begin
            ratio_ok_reg <= 1'b0;
        end else if (master) begin
            ratio_ok_reg <= 1'b1;
        end else if (left_start) begin
            ratio_ok_reg <= (cnt_reg == ratio - 10'h001);
        end else if (cnt_reg == 10'h3FF) begin
            ratio_ok_reg <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            hb_reg <= '0;
        end else begin
            hb_reg <= hb_reg + 3'h1;
        end
    end

    assign lnk.ratio_ok = ratio_ok_reg;
    assign lnk.heartbeat = hb_reg[2];
    assign word_select_clock_out = ws_out_reg;
    assign word_select_clock_oe = master & ~link_rst;

endmodule // cmcs_link

`default_nettype wire

// File: src/cmcs_supervisor.sv
// Top of the codec mute and clock supervisor.
// Assumes control pins and the serial output pin come from outside,
// samples and volumes from logic on ref_clk, and mclk free running.
`timescale 1ns/100ps
`default_nettype none

module cmcs_supervisor
    import cmcs_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic mclk,

    input wire logic word_select_clock_in,
    output logic word_select_clock_out,
    output logic word_select_clock_oe,
    output logic channel_is_left,
    output logic adc_pair_start,

    input wire logic power_down,
    input wire logic [1:0] clock_ratio_select,
    input wire logic high_rate_mode,
    input wire logic [1:0] port_role_select,
    input wire logic [7:0] mute2_ctrl,

    input wire logic control_clock_pin,
    input wire logic control_data_pin_in,
    output logic control_data_pin_out,
    output logic control_data_pin_oe,
    input wire logic addr_lsb_or_select_pin,
    input wire logic ctrl_data_drive_low,
    output logic ctrl_clk_level,
    output logic ctrl_data_level,
    output logic ctrl_two_wire,
    output logic ctrl_addr_lsb,
    output logic ctrl_port_enable,

    input wire logic serial_audio_out_in,
    output logic serial_audio_out,
    output logic serial_audio_out_oe,
    input wire logic serial_audio_out_data,

    input wire logic sample_frame_valid,
    input wire cmcs_pkg::cmcs_sample_t dac_sample [cmcs_pkg::NUM_CH],
    input wire cmcs_pkg::cmcs_vol_t channel_volume_regs [cmcs_pkg::NUM_CH],
    output cmcs_pkg::cmcs_sample_t dac_out [cmcs_pkg::NUM_CH],
    output logic dac_out_valid,

    output logic converter_enable,
    output logic mclk_present,
    output logic ratio_valid,
    output logic mute_ctrl_output
);

    cmcs_link_if lnk ();

    logic sdo_meta_reg, sdo_sync_reg;
    logic strap_done_reg;
    logic two_wire_reg;
    logic port_live_reg;

    logic cclk_meta_reg, cclk_sync_reg;
    logic cdat_meta_reg, cdat_sync_reg;
    logic asel_meta_reg, asel_sync_reg;

    logic [INIT_W-1:0] init_cnt_reg;
    logic init_done_reg;

    logic hb_meta_reg, hb_sync_reg, hb_prev_reg;
    logic [LOSS_W-1:0] loss_cnt_reg;
    logic mclk_ok_reg;
    logic rok_meta_reg, rok_sync_reg;

    logic [NUM_CH-1:0] ch_zero;
    logic all_zero;
    logic [ZRUN_W-1:0] zrun_reg;
    logic zero_mute;
    logic sw_mute;
    logic mute_any;

    ////////////////////////////////////////////////////////////////
    // Link domain.

    assign lnk.ratio_sel = clock_ratio_select;
    assign lnk.high_rate = high_rate_mode;
    assign lnk.role = port_role_select;

    cmcs_link u_link (
        .mclk(mclk),
        .reset(reset),
        .lnk(lnk.link),
        .word_select_clock_in(word_select_clock_in),
        .word_select_clock_out(word_select_clock_out),
        .word_select_clock_oe(word_select_clock_oe),
        .channel_is_left(channel_is_left),
        .adc_pair_start(adc_pair_start)
    );

    ////////////////////////////////////////////////////////////////
    // Pin synchronisers.

    always_ff @(posedge ref_clk) begin
        sdo_meta_reg <= serial_audio_out_in;
        sdo_sync_reg <= sdo_meta_reg;
        cclk_meta_reg <= control_clock_pin;
        cclk_sync_reg <= cclk_meta_reg;
        cdat_meta_reg <= control_data_pin_in;
        cdat_sync_reg <= cdat_meta_reg;
        asel_meta_reg <= addr_lsb_or_select_pin;
        asel_sync_reg <= asel_meta_reg;
        hb_meta_reg <= lnk.heartbeat;
        hb_sync_reg <= hb_meta_reg;
        rok_meta_reg <= lnk.ratio_ok;
        rok_sync_reg <= rok_meta_reg;
    end

    ////////////////////////////////////////////////////////////////
    // Control mode strap, caught on the first edge after release.

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            strap_done_reg <= 1'b0;
            two_wire_reg <= 1'b0;
        end else if (!strap_done_reg) begin
            strap_done_reg <= 1'b1;
            two_wire_reg <= (sdo_sync_reg == STRAP_TWO_WIRE_LEVEL);
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            port_live_reg <= 1'b0;
        end else begin
            port_live_reg <= strap_done_reg;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Control port pins.

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            ctrl_clk_level <= 1'b0;
            ctrl_data_level <= 1'b0;
            ctrl_two_wire <= 1'b0;
            ctrl_addr_lsb <= 1'b0;
            ctrl_port_enable <= 1'b0;
            control_data_pin_oe <= 1'b0;
        end else begin
            ctrl_clk_level <= port_live_reg & cclk_sync_reg;
            ctrl_data_level <= port_live_reg & cdat_sync_reg;
            ctrl_two_wire <= two_wire_reg;
            ctrl_addr_lsb <= two_wire_reg & asel_sync_reg;
            ctrl_port_enable <= port_live_reg & (two_wire_reg | ~asel_sync_reg);
            control_data_pin_oe <= port_live_reg & two_wire_reg & ctrl_data_drive_low;
        end
    end

    assign control_data_pin_out = 1'b0;

    ////////////////////////////////////////////////////////////////
    // Serial output pin, an input until the strap is taken.

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            serial_audio_out <= 1'b0;
            serial_audio_out_oe <= 1'b0;
        end else begin
            serial_audio_out <= serial_audio_out_data;
            serial_audio_out_oe <= port_live_reg;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Power-up initialisation.

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            init_cnt_reg <= '0;
            init_done_reg <= 1'b0;
        end else if (power_down) begin
            init_cnt_reg <= '0;
            init_done_reg <= 1'b0;
        end else if (!init_done_reg) begin
            init_cnt_reg <= init_cnt_reg + 11'h001;
            init_done_reg <= (init_cnt_reg == INIT_COUNT - 11'h001);
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            converter_enable <= 1'b0;
        end else begin
            converter_enable <= init_done_reg & ~power_down;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Master clock presence and ratio state.

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            hb_prev_reg <= 1'b0;
            loss_cnt_reg <= '0;
            mclk_ok_reg <= 1'b0;
        end else begin
            hb_prev_reg <= hb_sync_reg;
            if (hb_sync_reg != hb_prev_reg) begin
                loss_cnt_reg <= '0;
                mclk_ok_reg <= 1'b1;
            end else if (loss_cnt_reg == LOSS_COUNT) begin
                mclk_ok_reg <= 1'b0;
            end else begin
                loss_cnt_reg <= loss_cnt_reg + 8'h01;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            mclk_present <= 1'b0;
            ratio_valid <= 1'b0;
        end else begin
            mclk_present <= mclk_ok_reg;
            ratio_valid <= mclk_ok_reg & rok_sync_reg;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Zero-run detection.

    generate
        for (genvar i = 0; i < NUM_CH; i++) begin : g_zero
            assign ch_zero[i] = (dac_sample[i] == '0);
        end
    endgenerate

    assign all_zero = &ch_zero;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            zrun_reg <= '0;
        end else if (sample_frame_valid) begin
            if (!all_zero) begin
                zrun_reg <= '0;
            end else if (zrun_reg != ZERO_RUN_LEN) begin
                zrun_reg <= zrun_reg + 10'h001;
            end
        end
    end

    assign zero_mute = mute2_ctrl[MUTE2_ZERO_EN_BIT] & (zrun_reg == ZERO_RUN_LEN);
    assign sw_mute = mute2_ctrl[MUTE2_SW_MUTE_BIT];

    ////////////////////////////////////////////////////////////////
    // Mute control output, low while any cause stands.

    assign mute_any = power_down | ~init_done_reg | ~mclk_ok_reg
        | ~rok_sync_reg | sw_mute | zero_mute;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            mute_ctrl_output <= 1'b0;
        end else begin
            mute_ctrl_output <= ~mute_any;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Per-channel volume: 0.5 dB steps, twelve steps per halving.

    generate
        for (genvar i = 0; i < NUM_CH; i++) begin : g_vol
            cmcs_vol_t coarse;
            cmcs_vol_t fine;
            logic signed [SAMPLE_W+16:0] prod;
            logic signed [SAMPLE_W+16:0] scaled;

            assign coarse = channel_volume_regs[i] / STEPS_PER_HALVING;
            assign fine = channel_volume_regs[i] % STEPS_PER_HALVING;
            assign prod = dac_sample[i] * $signed({1'b0, GAIN_FRAC[fine[3:0]]});
            assign scaled = (prod >>> GAIN_FRAC_BITS) >>> coarse;

            always_ff @(posedge ref_clk or posedge reset) begin
                if (reset) begin
                    dac_out[i] <= '0;
                end else if (sample_frame_valid) begin
                    if (channel_volume_regs[i] > VOL_MAX) begin
                        dac_out[i] <= '0;
                    end else begin
                        dac_out[i] <= scaled[SAMPLE_W-1:0];
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            dac_out_valid <= 1'b0;
        end else begin
            dac_out_valid <= sample_frame_valid & converter_enable;
        end
    end

endmodule // cmcs_supervisor

`default_nettype wire

// File: testbench/cmcs_checker.sv
// Assertions on the ports of the codec mute and clock supervisor.
// Bound to every cmcs_supervisor instance, ref_clk domain only.
`timescale 1ns/100ps
`default_nettype none

module cmcs_checker (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic power_down,
    input wire logic [7:0] mute2_ctrl,
    input wire logic ctrl_data_drive_low,
    input wire logic control_data_pin_out,
    input wire logic control_data_pin_oe,
    input wire logic ctrl_two_wire,
    input wire logic sample_frame_valid,
    input wire logic dac_out_valid,
    input wire logic converter_enable,
    input wire logic mclk_present,
    input wire logic ratio_valid,
    input wire logic mute_ctrl_output
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);

    chk_init_mute: assert property (!converter_enable [*2] |-> !mute_ctrl_output)
        else $error("mute released before init");
    chk_soft_mute: assert property (mute2_ctrl[7] [*2] |-> !mute_ctrl_output)
        else $error("software mute ignored");
    chk_power_mute: assert property (power_down [*3] |-> !mute_ctrl_output)
        else $error("mute released in power down");
    chk_ratio_mute: assert property (!ratio_valid [*3] |-> !mute_ctrl_output)
        else $error("mute released on bad ratio");
    chk_clock_mute: assert property (!mclk_present [*3] |-> !mute_ctrl_output)
        else $error("mute released without mclk");
    chk_four_wire_oe: assert property (!ctrl_two_wire |-> !control_data_pin_oe)
        else $error("data pin driven in four-wire mode");
    chk_drive_oe: assert property (ctrl_two_wire && ctrl_data_drive_low |=> control_data_pin_oe)
        else $error("data pin not pulled low");
    chk_drive_stop: assert property (!ctrl_data_drive_low |=> !control_data_pin_oe)
        else $error("data pin pulled without request");
    chk_open_drain: assert property (control_data_pin_out == 1'b0)
        else $error("data pin driven high");
    chk_frame_out: assert property (sample_frame_valid && converter_enable |=> dac_out_valid)
        else $error("frame not passed on");
    chk_frame_only: assert property (dac_out_valid |-> $past(sample_frame_valid))
        else $error("output valid without frame");
endmodule // cmcs_checker

bind cmcs_supervisor cmcs_checker u_cmcs_checker (
    .ref_clk(ref_clk), .reset(reset), .power_down(power_down), .mute2_ctrl(mute2_ctrl),
    .ctrl_data_drive_low(ctrl_data_drive_low), .control_data_pin_out(control_data_pin_out),
    .control_data_pin_oe(control_data_pin_oe), .ctrl_two_wire(ctrl_two_wire),
    .sample_frame_valid(sample_frame_valid), .dac_out_valid(dac_out_valid),
    .converter_enable(converter_enable), .mclk_present(mclk_present),
    .ratio_valid(ratio_valid), .mute_ctrl_output(mute_ctrl_output));

`default_nettype wire

// File: testbench/cmcs_partner.sv
// Far-side decoder model: word select source for the slave role.
// Assumes mclk from the bench; the bench muxes it with the device drive.
`timescale 1ns/100ps
`default_nettype none

module cmcs_partner #(
    parameter int RATIO = 256
) (
    input wire logic mclk,
    input wire logic reset,
    output logic ws
);
    int cnt;

    // One word select period per RATIO master clocks, low half is left.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cnt <= 0;
        end else begin
            cnt <= (cnt == RATIO - 1) ? 0 : cnt + 1;
        end
    end
    assign ws = (cnt >= RATIO / 2);
endmodule // cmcs_partner

`default_nettype wire

// File: testbench/tb_cmcs_supervisor.sv
// Testbench of the codec mute and clock supervisor.
// Uses cmcs_partner for word select; cmcs_checker is bound in.
`timescale 1ns/100ps
`default_nettype none

module tb_cmcs_supervisor;
    import cmcs_pkg::*;
    logic ref_clk = 0, reset = 1, mclk = 0, mclk_run = 1, strap = 0, host_pull = 0, partner_ws;
    logic power_down = 0, high_rate_mode = 0, control_clock_pin = 0, addr_lsb_or_select_pin = 0;
    logic ctrl_data_drive_low = 0, serial_audio_out_data = 0, sample_frame_valid = 0;
    logic [1:0] clock_ratio_select = 2'h1, port_role_select = 2'h0;
    logic [7:0] mute2_ctrl = 8'h00;
    logic word_select_clock_in, word_select_clock_out, word_select_clock_oe, channel_is_left;
    logic adc_pair_start, control_data_pin_in, control_data_pin_out, control_data_pin_oe;
    logic ctrl_clk_level, ctrl_data_level, ctrl_two_wire, ctrl_addr_lsb, ctrl_port_enable;
    logic serial_audio_out_in, serial_audio_out, serial_audio_out_oe, dac_out_valid;
    logic converter_enable, mclk_present, ratio_valid, mute_ctrl_output;
    cmcs_sample_t dac_sample [NUM_CH], dac_out [NUM_CH];
    cmcs_vol_t channel_volume_regs [NUM_CH];
    int bad_count = 0, compares = 0, cyc = 0;

    always #4 ref_clk = ~ref_clk;
    initial begin
        #1.7;
        forever #6 mclk = mclk_run ? ~mclk : 1'b0;
    end

    assign word_select_clock_in = word_select_clock_oe ? word_select_clock_out : partner_ws;
    assign control_data_pin_in = !(control_data_pin_oe || host_pull);
    assign serial_audio_out_in = serial_audio_out_oe ? serial_audio_out : strap;

    cmcs_partner u_cmcs_partner (.mclk, .reset, .ws(partner_ws));
    cmcs_supervisor u_cmcs_supervisor (.ref_clk, .reset, .mclk, .word_select_clock_in,
        .word_select_clock_out, .word_select_clock_oe, .channel_is_left, .adc_pair_start,
        .power_down, .clock_ratio_select, .high_rate_mode, .port_role_select, .mute2_ctrl,
        .control_clock_pin, .control_data_pin_in, .control_data_pin_out, .control_data_pin_oe,
        .addr_lsb_or_select_pin, .ctrl_data_drive_low, .ctrl_clk_level, .ctrl_data_level,
        .ctrl_two_wire, .ctrl_addr_lsb, .ctrl_port_enable, .serial_audio_out_in,
        .serial_audio_out, .serial_audio_out_oe, .serial_audio_out_data, .sample_frame_valid, .dac_sample,
        .channel_volume_regs, .dac_out, .dac_out_valid, .converter_enable, .mclk_present,
        .ratio_valid, .mute_ctrl_output);

    ////////////////////////////////////////////////////////////////////////
    task automatic test_done;
        $display("compares %0d, bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 30000) begin
            bad_count++;
            $display("unexpected at %0t: run timed out", $time);
            test_done;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic frame(input cmcs_sample_t v, input int n = 1);
        foreach (dac_sample[i]) dac_sample[i] = v;
        sample_frame_valid = 1;
        wt(n);
        sample_frame_valid = 0;
    endtask

    // Waits a bounded time for the mute output to reach a level, then judges it.
    task automatic expect_mute(input logic lvl);
        for (int k = 0; k < 4000 && mute_ctrl_output !== lvl; k++) wt(1);
        chk(mute_ctrl_output, lvl, "mute output level");
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_two_wire;
        chk(ctrl_two_wire, 1, "strap low not two-wire");
        chk(serial_audio_out_oe, 1, "serial out not live");
        addr_lsb_or_select_pin = 1;
        control_clock_pin = 1;
        serial_audio_out_data = 1;
        wt(4);
        chk(serial_audio_out, 1, "serial data lost");
        chk(ctrl_addr_lsb, 1, "address bit");
        chk(ctrl_clk_level, 1, "control clock level");
        ctrl_data_drive_low = 1;
        wt(2);
        chk(control_data_pin_oe, 1, "no pull low");
        wt(3);
        chk(ctrl_data_level, 0, "data level low");
        ctrl_data_drive_low = 0;
        wt(5);
        chk(ctrl_data_level, 1, "data level high");
        host_pull = 1;
        wt(5);
        chk(ctrl_data_level, 0, "host pull unseen");
        host_pull = 0;
        control_clock_pin = 0;
    endtask

    task automatic t_volume;
        foreach (channel_volume_regs[i]) channel_volume_regs[i] = 8'(12 * i);
        frame(24'h123440);
        chk(dac_out_valid, 1, "frame valid");
        foreach (dac_out[i]) chk(32'(dac_out[i]), 32'(24'h123440 >> i), "volume scale");
    endtask

    task automatic t_soft_mute;
        mute2_ctrl = 8'h80;
        wt(3);
        chk(mute_ctrl_output, 0, "software mute");
        mute2_ctrl = 8'h00;
        expect_mute(1);
    endtask

    task automatic t_zero_run;
        mute2_ctrl = 8'h40;
        frame(24'h000001);
        wt(1);
        frame(24'h000000, 511);
        wt(3);
        chk(mute_ctrl_output, 1, "muted early");
        frame(24'h000000);
        wt(3);
        chk(mute_ctrl_output, 0, "no zero-run mute");
        frame(24'h000001);
        wt(3);
        chk(mute_ctrl_output, 1, "nonzero not released");
        mute2_ctrl = 8'h00;
        frame(24'h000000, 512);
        wt(3);
        chk(mute_ctrl_output, 1, "muted while disabled");
        frame(24'h000001);
    endtask

    task automatic t_clocks;
        logic ws_a;
        for (int r = 1; r < 3; r++) begin
            port_role_select = 2'(r);
            wt(20);
            chk(mute_ctrl_output, 0, "reserved role not muted");
        end
        port_role_select = 2'h3;
        wt(10);
        chk(word_select_clock_oe, 1, "master not driving");
        ws_a = word_select_clock_out;
        wt(192);
        chk(word_select_clock_out, !ws_a, "word select half period");
        expect_mute(1);
        port_role_select = 2'h0;
        wt(10);
        chk(word_select_clock_oe, 0, "slave still driving");
        high_rate_mode = 1;
        clock_ratio_select = 2'h3;
        wt(1000);
        expect_mute(1);
        clock_ratio_select = 2'h0;
        wt(1500);
        chk(mute_ctrl_output, 0, "wrong ratio not muted");
        high_rate_mode = 0;
        clock_ratio_select = 2'h1;
        expect_mute(1);
        power_down = 1;
        wt(4);
        chk(mute_ctrl_output, 0, "power down not muted");
        power_down = 0;
        expect_mute(1);
        mclk_run = 0;
        wt(200);
        chk(mclk_present, 0, "mclk loss unseen");
        chk(mute_ctrl_output, 0, "mclk loss not muted");
        mclk_run = 1;
        expect_mute(1);
    endtask

    task automatic t_four_wire;
        strap = 1;
        reset = 1;
        control_clock_pin = 1;
        wt(6);
        chk(ctrl_clk_level, 0, "port live in reset");
        chk(mute_ctrl_output, 0, "mute high in reset");
        reset = 0;
        addr_lsb_or_select_pin = 0;
        wt(5);
        chk(ctrl_two_wire, 0, "strap high not four-wire");
        chk(ctrl_port_enable, 1, "select low refused");
        addr_lsb_or_select_pin = 1;
        ctrl_data_drive_low = 1;
        wt(5);
        chk(ctrl_port_enable, 0, "select high accepted");
        chk(control_data_pin_oe, 0, "input pin driven");
        ctrl_data_drive_low = 0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        foreach (dac_sample[i]) dac_sample[i] = '0;
        foreach (channel_volume_regs[i]) channel_volume_regs[i] = '0;
        wt(6);
        chk(mute_ctrl_output, 0, "mute high in reset");
        chk(word_select_clock_oe, 0, "word select driven in reset");
        reset = 0;
        wt(4);
        t_two_wire();
        expect_mute(1);
        t_volume();
        t_soft_mute();
        t_zero_run();
        t_clocks();
        t_four_wire();
        test_done();
    end
endmodule // tb_cmcs_supervisor

`default_nettype wire
